/* dic_digital_input_conditioner.sv */
// Binary input conditioner: sampling, polarity, delays, relay drive
//
// Overview of operation
// - Sample every input once per 5 ms scan.
// - Polarity bit one inverts the energised state.
// - Programmable millisecond delay on 0 to 1.
// - Separate programmable millisecond delay on 1 to 0.
// - AC mode adds fixed 30 ms drop-off.
// - Logic state takes effect on next scan.
// - Routed relay follows one further scan later.
// - Relay outputs update only on a scan tick.
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps

module dic_digital_input_conditioner #(
    parameter int unsigned NUM_IN    = 8,
    parameter int unsigned NUM_OUT   = 8,
    parameter int unsigned MS_CYCLES = dic_pkg::MS_CYCLES
) (
    // Clock and reset
    input  wire logic                       clock,
    input  wire logic                       rst,
    // Field inputs, asynchronous to clock
    input  wire logic [NUM_IN-1:0]          binary_input_n,
    // Register port
    input  wire logic [dic_pkg::ADDR_W-1:0] addr,
    input  wire logic [dic_pkg::DATA_W-1:0] wrData,
    input  wire logic                       wrStrobe,
    input  wire logic                       rdStrobe,
    output logic      [dic_pkg::DATA_W-1:0] rdData,
    // Relay drive and interrupt
    output logic      [NUM_OUT-1:0]         output_relay_n,
    output logic                            irq
);
    import dic_pkg::*;
    // Timebase: one clock, with the millisecond and scan rates made
    // as one-cycle enable pulses, never as derived clocks.
    // MS_CYCLES is a parameter so a bench can shorten a millisecond
    // without touching the scan or delay arithmetic below.

    // Derived counts for the dividers and the AC allowance
    localparam int unsigned MSC_W = $clog2(MS_CYCLES);
    localparam logic [MSC_W-1:0] MS_LAST = MSC_W'(MS_CYCLES - 1);
    localparam logic [2:0] SCAN_LAST = 3'(SCAN_MS - 1);
    localparam logic [DLY_W-1:0] AC_EXTRA = DLY_W'(AC_DELAY_MS);

    // State is kept per concern; each always_ff below owns exactly
    // the variables that it assigns
    // Synchroniser stages; stage one feeds only stage two
    logic [NUM_IN-1:0]  syncA_r;
    logic [NUM_IN-1:0]  syncB_r;
    // Timebase
    logic [MSC_W-1:0]   msCnt_r;      // Cycles within a millisecond
    logic               msTick_r;     // One-cycle millisecond pulse
    logic [2:0]         scanCnt_r;    // Milliseconds within a scan
    logic               scanTick;     // One-cycle scan pulse
    // Pipeline state
    logic [NUM_IN-1:0]  sampled_r;    // Raw state caught at scan
    logic [NUM_IN-1:0]  polarized;    // After polarity applied
    logic [NUM_IN-1:0]  filtered;     // After delay timers
    logic [NUM_IN-1:0]  logicState_r; // State seen by internal logic
    logic [NUM_IN-1:0]  logicPrev_r;  // For change detection
    // Configuration
    logic [NUM_IN-1:0]  polarity_r;   // One means normally closed
    logic [NUM_IN-1:0]  acMode_r;     // One means AC mode enabled
    logic [DLY_W-1:0]   actDelay_r  [NUM_IN];
    logic [DLY_W-1:0]   dropDelay_r [NUM_IN];
    logic [NUM_OUT-1:0] route_r;      // Relay follows its input
    logic [NUM_OUT-1:0] relaySw_r;    // Software relay command
    // Interrupt state
    logic [NUM_IN-1:0]  intStat_r;
    logic [NUM_IN-1:0]  intMask_r;
    logic [NUM_IN-1:0]  changeEv;
    // Bus output registers
    logic [DATA_W-1:0]  rdData_r;
    logic [NUM_OUT-1:0] relay_r;
    logic               irq_r;

    assign rdData         = rdData_r;
    assign output_relay_n = relay_r;
    assign irq            = irq_r;

    // Field pins are asynchronous; a single flop could go metastable
    // and hand two different values to the logic behind it
    // Two-stage synchroniser for the field pins
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            syncA_r <= '0;
            syncB_r <= '0;
        end else begin
            syncA_r <= binary_input_n;
            syncB_r <= syncA_r;
        end
    end

    // Registered tick keeps the counter compare off the paths of
    // every timer that uses it
    // Millisecond divider; one pulse every MS_CYCLES clocks
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            msCnt_r  <= '0;
            msTick_r <= 1'b0;
        end else if (msCnt_r == MS_LAST) begin
            msCnt_r  <= '0;
            msTick_r <= 1'b1;
        end else begin
            msCnt_r  <= msCnt_r + 1'b1;
            msTick_r <= 1'b0;
        end
    end

    // The scan counter only moves on a millisecond tick, so a scan
    // is exactly SCAN_MS milliseconds whatever MS_CYCLES is
    // Scan divider; every fifth millisecond tick is a scan
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            scanCnt_r <= '0;
        end else if (msTick_r) begin
            if (scanCnt_r == SCAN_LAST) begin
                scanCnt_r <= '0;
            end else begin
                scanCnt_r <= scanCnt_r + 1'b1;
            end
        end
    end

    // Scan pulse lasts the same single cycle as its millisecond tick
    assign scanTick = msTick_r && (scanCnt_r == SCAN_LAST);

    // A change between two scans stays unseen until the next one,
    // which gives the 0 to 5 ms spread of the sampled state
    // Inputs are only looked at once per scan
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sampled_r <= '0;
        end else if (scanTick) begin
            sampled_r <= syncB_r;
        end
    end

    // Polarity acts after sampling, so a new setting takes effect at
    // once and then runs through the ordinary delay timers
    // Normally closed inputs report 0 when energised
    assign polarized = sampled_r ^ polarity_r;

    // Per-input delay filter
    // One timer per input; it counts milliseconds while the polarised
    // sample differs from the filtered state, and the delay in force
    // is chosen by the direction of the pending change.
    // Limitation: whole ticks are counted, so a change may pass up to
    // one millisecond before its nominal delay, depending on phase.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_IN; gi++) begin : gFilt
            logic [DLY_W-1:0] cnt_r;   // Elapsed milliseconds
            logic             state_r; // Filtered state
            logic [DLY_W-1:0] limit;   // Delay for pending change

            // Rising changes use the activation delay alone
            // In AC mode the drop-off limit grows by the fixed AC allowance
            always_comb begin
                if (polarized[gi]) begin
                    limit = actDelay_r[gi];
                end else if (acMode_r[gi]) begin
                    limit = dropDelay_r[gi] + AC_EXTRA;
                end else begin
                    limit = dropDelay_r[gi];
                end
            end

            // Timer runs on the millisecond tick while a change pends
            // Counter never passes the limit, so the delay field width
            // is enough for the timer as well
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    cnt_r   <= '0;
                    state_r <= 1'b0;
                end else if (polarized[gi] == state_r) begin
                    // Sample reverted; pending change dropped
                    cnt_r <= '0;
                end else if (cnt_r >= limit) begin
                    // Zero delay passes on the next clock
                    state_r <= polarized[gi];
                    cnt_r   <= '0;
                end else if (msTick_r) begin
                    cnt_r <= cnt_r + 1'b1;
                end
            end

            assign filtered[gi] = state_r;
        end
    endgenerate

    // Internal logic sees filtered state on the following scan
    // Logic and relay routing thus act on one consistent snapshot;
    // logicPrev trails by one clock to turn a change into a pulse
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            logicState_r <= '0;
            logicPrev_r  <= '0;
        end else begin
            logicPrev_r <= logicState_r;
            if (scanTick) begin
                logicState_r <= filtered;
            end
        end
    end

    // One-cycle pulse on either edge of a logic state bit; both
    // reset to zero, so no false event follows reset
    assign changeEv = logicState_r ^ logicPrev_r;

    // Relays refresh on the scan; routed ones lag one more scan
    // They take the logic state held before this scan's update, which
    // gives routed inputs their extra scan. Unrouted relays, and relays
    // without a matching input, follow the software command.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            relay_r <= '0;
        end else if (scanTick) begin
            for (int i = 0; i < NUM_OUT; i++) begin
                // Index check keeps a short input vector from aliasing
                if (route_r[i] && (i < NUM_IN)) begin
                    relay_r[i] <= logicState_r[i % NUM_IN];
                end else begin
                    relay_r[i] <= relaySw_r[i];
                end
            end
        end
    end

    // Configuration writes
    // Writes act on the strobe edge; read-only and unmapped words are
    // ignored. A new delay value applies to a change already pending.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            polarity_r <= RST_POLARITY[NUM_IN-1:0];
            acMode_r   <= RST_ACMODE[NUM_IN-1:0];
            route_r    <= '0;
            relaySw_r  <= '0;
            intMask_r  <= '0;
            for (int i = 0; i < NUM_IN; i++) begin
                actDelay_r[i]  <= RST_DELAY;
                dropDelay_r[i] <= RST_DELAY;
            end
        end else if (wrStrobe) begin
            if (addr == ADDR_POLARITY) begin
                polarity_r <= wrData[NUM_IN-1:0];
            end else if (addr == ADDR_ACMODE) begin
                acMode_r <= wrData[NUM_IN-1:0];
            end else if (addr == ADDR_INTMASK) begin
                intMask_r <= wrData[NUM_IN-1:0];
            end else if (addr == ADDR_ROUTE) begin
                route_r <= wrData[NUM_OUT-1:0];
            end else if (addr == ADDR_RELAYSW) begin
                relaySw_r <= wrData[NUM_OUT-1:0];
            end else begin
                // Delay words; values above the range are clipped
                // Windows of 16 words bound NUM_IN to 16
                for (int i = 0; i < NUM_IN; i++) begin
                    if (addr == ADDR_ACTDLY + 8'(i)) begin
                        actDelay_r[i] <= clipDelay(wrData);
                    end else if (addr == ADDR_DROPDLY + 8'(i)) begin
                        dropDelay_r[i] <= clipDelay(wrData);
                    end
                end
            end
        end
    end

    // Keep settings inside the supported range
    // Saturating instead of wrapping keeps an oversized setting from
    // turning into a short delay
    function automatic logic [DLY_W-1:0] clipDelay(
        input logic [DATA_W-1:0] v
    );
        if (v > DATA_W'(MAX_DELAY_MS)) begin
            clipDelay = DLY_W'(MAX_DELAY_MS);
        end else begin
            clipDelay = v[DLY_W-1:0];
        end
    endfunction

    // Sticky change flags; a new event beats a same-cycle clear
    // So no change is lost between software's read and its clear;
    // writing a one clears a flag, writing a zero leaves it
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            intStat_r <= '0;
        end else if (wrStrobe && (addr == ADDR_INTSTAT)) begin
            intStat_r <= (intStat_r & ~wrData[NUM_IN-1:0]) | changeEv;
        end else begin
            intStat_r <= intStat_r | changeEv;
        end
    end

    // Level interrupt from any unmasked flag
    // Registered, so irq lags the flags and mask by one clock; a mask
    // write shows on irq at the first edge after the write edge
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(intStat_r & intMask_r);
        end
    end

    // Read data valid in the cycle after the strobe only
    // Zero outside the read cycle keeps the bus quiet and lets a
    // shared read mux simply OR several slaves together
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdData_r <= '0;
        end else if (!rdStrobe) begin
            rdData_r <= '0;
        end else if (addr == ADDR_POLARITY) begin
            rdData_r <= DATA_W'(polarity_r);
        end else if (addr == ADDR_ACMODE) begin
            rdData_r <= DATA_W'(acMode_r);
        end else if (addr == ADDR_STATE) begin
            rdData_r <= DATA_W'(logicState_r);
        end else if (addr == ADDR_SAMPLED) begin
            rdData_r <= DATA_W'(sampled_r);
        end else if (addr == ADDR_INTSTAT) begin
            rdData_r <= DATA_W'(intStat_r);
        end else if (addr == ADDR_INTMASK) begin
            rdData_r <= DATA_W'(intMask_r);
        end else if (addr == ADDR_ROUTE) begin
            rdData_r <= DATA_W'(route_r);
        end else if (addr == ADDR_RELAYSW) begin
            rdData_r <= DATA_W'(relaySw_r);
        end else begin
            // Delay words, else unmapped reads zero
            rdData_r <= '0;
            for (int i = 0; i < NUM_IN; i++) begin
                if (addr == ADDR_ACTDLY + 8'(i)) begin
                    rdData_r <= DATA_W'(actDelay_r[i]);
                end else if (addr == ADDR_DROPDLY + 8'(i)) begin
                    rdData_r <= DATA_W'(dropDelay_r[i]);
                end
            end
        end
    end
endmodule

/* dic_field_model.sv */
// Field voltage source for the conditioner's inputs
`timescale 1ns/1ps
module dic_field_model #(
    parameter int unsigned NUM_IN = 8
) (
    // Clock that field changes are aligned to
    input  wire logic              clock,
    // Energised state of each field input
    output logic      [NUM_IN-1:0] binary_input_n
);
    // All inputs start de-energised
    initial binary_input_n = '0;
    // Change lands just after an edge, never on it
    task automatic setIn(input int i, input logic v);
        @(posedge clock);
        binary_input_n[i] <= v;
    endtask
endmodule

/* dic_pkg.sv */
// Constants shared by the digital input conditioner
package dic_pkg;
    // Clock rate and timebase
    localparam int unsigned CLK_HZ       = 40_000_000;
    localparam int unsigned TICK_MS      = 1;
    localparam int unsigned MS_CYCLES    = CLK_HZ / 1000 * TICK_MS;
    // Scan period in milliseconds
    localparam int unsigned SCAN_MS      = 5;
    // Fixed extra drop-off delay in AC mode, milliseconds
    localparam int unsigned AC_DELAY_MS  = 30;
    // Longest settable delay, milliseconds
    localparam int unsigned MAX_DELAY_MS = 1_800_000;
    // Delay field width, holds MAX_DELAY_MS plus AC_DELAY_MS
    localparam int unsigned DLY_W        = 21;
    // Bus widths
    localparam int unsigned ADDR_W       = 8;
    localparam int unsigned DATA_W       = 32;
    // Register word addresses
    localparam logic [7:0] ADDR_POLARITY = 8'h00;
    localparam logic [7:0] ADDR_ACMODE   = 8'h01;
    localparam logic [7:0] ADDR_STATE    = 8'h02;
    localparam logic [7:0] ADDR_SAMPLED  = 8'h03;
    localparam logic [7:0] ADDR_INTSTAT  = 8'h04;
    localparam logic [7:0] ADDR_INTMASK  = 8'h05;
    localparam logic [7:0] ADDR_ROUTE    = 8'h06;
    localparam logic [7:0] ADDR_RELAYSW  = 8'h07;
    localparam logic [7:0] ADDR_ACTDLY   = 8'h10;
    localparam logic [7:0] ADDR_DROPDLY  = 8'h20;
    // Reset values
    localparam logic [31:0] RST_POLARITY = 32'h0000_0000;
    localparam logic [31:0] RST_ACMODE   = 32'h0000_0000;
    localparam logic [20:0] RST_DELAY    = 21'h00_0000;
endpackage

/* dic_props.sv */
// Port checker for the digital input conditioner
`timescale 1ns/1ps
module dic_props #(
    parameter int unsigned NUM_IN    = 8,
    parameter int unsigned NUM_OUT   = 8,
    parameter int unsigned MS_CYCLES = 4
) (
    // Clock and reset
    input wire logic                       clock,
    input wire logic                       rst,
    // Register port
    input wire logic [dic_pkg::ADDR_W-1:0] addr,
    input wire logic [dic_pkg::DATA_W-1:0] wrData,
    input wire logic                       wrStrobe,
    input wire logic                       rdStrobe,
    input wire logic [dic_pkg::DATA_W-1:0] rdData,
    // Relay drive and interrupt
    input wire logic [NUM_OUT-1:0]         output_relay_n,
    input wire logic                       irq
);
    import dic_pkg::*;
    // Implemented polarity and mode bits
    localparam logic [31:0] IN_MASK = 32'((64'h1 << NUM_IN) - 1);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    logic [NUM_OUT-1:0] relayQ_r;   // Relay value one cycle ago
    logic [31:0]        sinceChg_r; // Cycles since the last change
    wire                relayChg = relayQ_r != output_relay_n;
    // Saturates so the first change after reset never fires
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            relayQ_r   <= '0;
            sinceChg_r <= 32'hffff_ffff;
        end else begin
            relayQ_r <= output_relay_n;
            if (relayChg)
                sinceChg_r <= 32'h0000_0000;
            else if (sinceChg_r != 32'hffff_ffff)
                sinceChg_r <= sinceChg_r + 32'h0000_0001;
        end
    end
    // Delay settings are clipped at the top of range
    function automatic logic [31:0] clip(input logic [31:0] v);
        return (v > MAX_DELAY_MS) ? MAX_DELAY_MS : v;
    endfunction
    property p_rdIdle;
        !$past(rdStrobe) |-> rdData == '0;
    endproperty
    a_rdIdle: assert property (p_rdIdle) else $error("rdData not idle");
    property p_unmapped;
        rdStrobe && addr >= 8'h30 |=> rdData == '0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    property p_polBack;
        wrStrobe && addr == ADDR_POLARITY ##1
        rdStrobe && addr == ADDR_POLARITY
        |=> rdData == ($past(wrData, 2) & IN_MASK);
    endproperty
    a_polBack: assert property (p_polBack) else $error("polarity");
    property p_acBack;
        wrStrobe && addr == ADDR_ACMODE ##1 rdStrobe && addr == ADDR_ACMODE
        |=> rdData == ($past(wrData, 2) & IN_MASK);
    endproperty
    a_acBack: assert property (p_acBack) else $error("AC mode");
    property p_actBack;
        wrStrobe && addr[7:4] == 4'h1 && addr[3:0] < NUM_IN ##1
        rdStrobe && addr == $past(addr) |=> rdData == clip($past(wrData, 2));
    endproperty
    a_actBack: assert property (p_actBack) else $error("rise delay");
    property p_dropBack;
        wrStrobe && addr[7:4] == 4'h2 && addr[3:0] < NUM_IN ##1
        rdStrobe && addr == $past(addr) |=> rdData == clip($past(wrData, 2));
    endproperty
    a_dropBack: assert property (p_dropBack) else $error("drop");
    property p_relayScan;
        relayChg |-> sinceChg_r >= SCAN_MS * MS_CYCLES - 1;
    endproperty
    a_relayScan: assert property (p_relayScan) else $error("relay");
    property p_maskOff;
        wrStrobe && addr == ADDR_INTMASK && wrData == '0 |-> ##2 !irq;
    endproperty
    a_maskOff: assert property (p_maskOff) else $error("irq not masked");
    c_relay: cover property (relayChg);
    c_irq: cover property ($rose(irq));
    c_clip: cover property (rdStrobe ##1 rdData == MAX_DELAY_MS);
endmodule

/* test_digital_input_conditioner.sv */
// Self-checking bench for the digital input conditioner
`timescale 1ns/1ps
module test_digital_input_conditioner;
    import dic_pkg::*;
    localparam int unsigned MSC  = 4;       // Shortened millisecond
    localparam int unsigned SCAN = 5 * MSC; // Scan period in clocks
    typedef struct packed {
        logic        wr;
        logic [7:0]  a;
        logic [31:0] d;
        logic [31:0] e;
    } dic_row_t;
    // Reset values, then write and read back
    localparam dic_row_t ROWS [13] = '{
        '{1'b0, 8'h00, 32'h0, 32'h0}, '{1'b0, 8'h01, 32'h0, 32'h0},
        '{1'b0, 8'h10, 32'h0, 32'h0}, '{1'b0, 8'h20, 32'h0, 32'h0},
        '{1'b1, 8'h00, 32'h1, 32'h1}, '{1'b1, 8'h01, 32'h2, 32'h2},
        '{1'b1, 8'h10, 32'h3, 32'h3}, '{1'b1, 8'h14, 32'h14, 32'h14},
        '{1'b1, 8'h12, 32'h1fffff, 32'h1b7740},
        '{1'b1, 8'h21, 32'h2, 32'h2}, '{1'b1, 8'h06, 32'hff, 32'hff},
        '{1'b1, 8'h05, 32'hff, 32'hff}, '{1'b1, 8'h30, 32'h1, 32'h0}};
    logic              clock;
    logic              rst;
    logic [7:0]        fieldIn;  // Field inputs from the model
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wrData;
    logic              wrStrobe;
    logic              rdStrobe;
    logic [DATA_W-1:0] rdData;
    logic [7:0]        relay;
    logic              irq;
    logic [31:0]       q;        // Last read result
    int                n;        // Cycles counted by the last wait
    int                n_mismatch;
    int                compares;
    dic_field_model model (.clock(clock), .binary_input_n(fieldIn));
    dic_digital_input_conditioner #(.MS_CYCLES(MSC)) DUT (
        .clock(clock), .rst(rst), .binary_input_n(fieldIn), .addr(addr),
        .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
        .rdData(rdData), .output_relay_n(relay), .irq(irq));
    // 40 MHz clock
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    task automatic test_done;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask
    // Strobe left high so a read may follow with no gap
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wrData <= d;
        wrStrobe <= 1'b1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clock);
        addr <= a;
        wrStrobe <= 1'b0;
        rdStrobe <= 1'b1;
        @(posedge clock);
        rdStrobe <= 1'b0;
        #1 v = rdData;
    endtask
    // Idle cycles, also ending a pending write; returns off the edge
    task automatic pause(input int k);
        repeat (k) begin
            @(posedge clock);
            wrStrobe <= 1'b0;
        end
        #1;
    endtask
    task automatic waitRelay(input int i, input logic v, input int lim);
        n = 0;
        while (relay[i] !== v) begin
            @(posedge clock);
            #1 n++;
            if (n > lim) begin
                n_mismatch++;
                $display("wrong value at %0t: relay %0d stuck", $time, i);
                test_done();
            end
        end
    endtask
    initial begin
        rst = 1'b1;
        addr = '0;
        wrData = '0;
        wrStrobe = 1'b0;
        rdStrobe = 1'b0;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        #1 chk({23'h0, irq, relay}, 32'h0);
        foreach (ROWS[k]) begin
            if (ROWS[k].wr) wr(ROWS[k].a, ROWS[k].d);
            rd(ROWS[k].a, q);
            chk(q, ROWS[k].e);
        end
        // Closed contact on input 0 reads active while de-energised
        pause(8 * SCAN);
        rd(8'h02, q);
        chk(q, 32'h1);
        chk({24'h0, relay}, 32'h1);
        chk({31'h0, irq}, 32'h1);
        wr(8'h04, 32'hff);
        pause(3);
        chk({31'h0, irq}, 32'h0);
        rd(8'h04, q);
        chk(q, 32'h0);
        // Latency from field to routed relay
        model.setIn(3, 1'b1);
        waitRelay(3, 1'b1, 4 * SCAN);
        chk(32'(n >= 2 * SCAN && n <= 3 * SCAN + 8), 32'h1);
        chk({31'h0, irq}, 32'h1);
        // AC input: drop time plus the fixed extra delay
        model.setIn(1, 1'b1);
        waitRelay(1, 1'b1, 4 * SCAN);
        model.setIn(1, 1'b0);
        waitRelay(1, 1'b0, 40 * MSC + 4 * SCAN);
        chk(32'(n >= 31 * MSC && n <= 32 * MSC + 3 * SCAN + 8), 1);
        // Short pulses must not add up towards the rise delay
        repeat (4) begin
            model.setIn(4, 1'b1);
            pause(2 * SCAN);
            model.setIn(4, 1'b0);
            pause(2 * SCAN);
        end
        pause(4 * SCAN);
        chk({31'h0, relay[4]}, 32'h0);
        rd(8'h03, q);
        chk(q, 32'h8);
        // Unrouted relay follows the software command
        wr(8'h06, 32'h7f);
        wr(8'h07, 32'h80);
        pause(2 * SCAN);
        chk({31'h0, relay[7]}, 32'h1);
        // Masked change keeps the interrupt low
        wr(8'h05, 32'h0);
        pause(2);
        model.setIn(3, 1'b0);
        pause(4 * SCAN);
        chk({31'h0, irq}, 32'h0);
        chk({31'h0, relay[3]}, 32'h0);
        // Second reset in mid-run restores defaults
        rst <= 1'b1;
        pause(2);
        rst <= 1'b0;
        rd(8'h10, q);
        chk(q, 32'h0);
        chk({24'h0, relay}, 32'h0);
        test_done();
    end
endmodule
bind dic_digital_input_conditioner dic_props #(
    .NUM_IN(NUM_IN), .NUM_OUT(NUM_OUT), .MS_CYCLES(MS_CYCLES)
) uProps (.clock, .rst, .addr, .wrData, .wrStrobe, .rdStrobe, .rdData,
    .output_relay_n, .irq);
